// file: design/nbb_base_regs.v
// base address registers two, three and the configuration window
`timescale 1ns/10ps
//
// Behaviour
// - register two type field mirrors setup two type; 0 narrow, 2 wide
// - register two type field reads zero when io space selected
// - prefetch bit 3 mirrors setup prefetch, zero when io space
// - register two base bits 31:4 reset zero, writable per setup size
// - base fields are compared with incoming addresses to claim them
// - in wide mode register three is the upper 32 base bits
// - register three reports narrow address type unless register two is wide
// - register three base bits reset zero, writable per setup three size, or per setup two size in wide mode
// - window register maps whole configuration space into memory
// - window register space bit hardwired to memory
// - window register type field always narrow
// - window prefetch reads zero, bits 6:4 reserved zero
// - window requests 4KB, base field 31:12 writable, 11:7 read zero, resets zero
module nbb_base_regs (
  input wire i_clock,
  input wire i_rst_b,
  input wire i_reg_wr,
  input wire i_reg_rd,
  input wire [11:0] i_reg_addr,
  input wire [31:0] i_reg_wdata,
  input wire [3:0] i_reg_be,
  input wire i_setup_two_space,
  input wire [1:0] i_setup_two_type,
  input wire i_setup_two_prefetchable_flag,
  input wire [5:0] i_setup_two_size,
  input wire i_setup_three_space,
  input wire i_setup_three_prefetchable_flag,
  input wire [5:0] i_setup_three_size,
  input wire i_req_valid,
  input wire i_req_is_io,
  input wire [63:0] i_req_addr,
  output reg [31:0] o_reg_rdata,
  output reg o_reg_ack,
  output reg o_hit_two,
  output reg o_hit_three,
  output reg o_hit_cfg,
  output reg [11:0] o_cfg_offset
);
`include "nbb_defines.vh"

  ////////////////////////////////////////////////////////////////////////
  // window masks from a log2 size; below the minimum nothing decodes

  function [63:0] size_mask;
    input [5:0] log2;
    integer i;
    begin
      size_mask = 64'h0;
      if (log2 >= `NBB_MIN_LOG2) begin
        for (i = 4; i < 64; i = i + 1) begin
          size_mask[i] = (i >= log2);
        end
      end
    end
  endfunction

  wire two_io = (i_setup_two_space == `NBB_SPACE_IO);
  wire two_wide = !two_io && (i_setup_two_type == `NBB_TYPE_WIDE);
  wire three_io = (i_setup_three_space == `NBB_SPACE_IO);
  wire [63:0] mask_two_full = size_mask(i_setup_two_size);
  wire [63:0] mask_three_full = size_mask(i_setup_three_size);
  wire [63:0] mask_cfg_full = size_mask(`NBB_CFG_WIN_LOG2);
  // a narrow window of 4GB or larger cannot exist, so it is disabled
  wire two_en = |mask_two_full &&
                (two_wide || i_setup_two_size <= `NBB_MAX_NARROW_LOG2);
  wire three_en = |mask_three_full &&
                  i_setup_three_size <= `NBB_MAX_NARROW_LOG2;

  wire [31:0] mask_two = two_en ? mask_two_full[31:0] : 32'h0;
  wire [31:0] mask_three = two_wide ? mask_two_full[63:32]
                         : (three_en ? mask_three_full[31:0] : 32'h0);
  wire [31:0] mask_cfg = mask_cfg_full[31:0];

  ////////////////////////////////////////////////////////////////////////
  // storage, one masked word per register

  wire [2:0] wr_sel;
  wire [95:0] mask_all = {mask_cfg, mask_three, mask_two};
  wire [95:0] val_all;

  ////////////////////////////////////////////////////////////////////////
  // decode shared by the write strobes and the read mux

  // one-hot select of the addressed register, zero when unmapped
  function [2:0] reg_select;
    input [11:0] addr;
    begin
      reg_select = 3'h0;
      case (addr)
        `NBB_OFF_BAR_TWO: begin
          reg_select = 3'h1;
        end
        `NBB_OFF_BAR_THREE: begin
          reg_select = 3'h2;
        end
        `NBB_OFF_CFG_WIN: begin
          reg_select = 3'h4;
        end
        default: begin
          reg_select = 3'h0;
        end
      endcase
    end
  endfunction

  // masked compare; a narrow window passes all ones in the upper mask
  // so that any upper address bit set misses the window
  function window_match;
    input [63:0] addr;
    input [63:0] base;
    input [63:0] mask;
    begin
      window_match = (((addr ^ base) & mask) == 64'h0);
    end
  endfunction

  wire [2:0] reg_sel = reg_select(i_reg_addr);

  genvar g;
  generate
    for (g = 0; g < 3; g = g + 1) begin : gen_word
      assign wr_sel[g] = i_reg_wr && reg_sel[g];
      nbb_bar_word #(
        .WIDTH(32)
      ) u_word (
        .i_clock(i_clock),
        .i_rst_b(i_rst_b),
        .i_wr(wr_sel[g]),
        .i_wdata(i_reg_wdata),
        .i_be(i_reg_be),
        .i_mask(mask_all[g*32 +: 32]),
        .o_value(val_all[g*32 +: 32])
      );
    end
  endgenerate

  wire [31:0] base_two = val_all[31:0];
  wire [31:0] base_three = val_all[63:32];
  wire [31:0] base_cfg = val_all[95:64];

  ////////////////////////////////////////////////////////////////////////
  // read views; low attribute bits come from setup or are hardwired, never from the write, except register three in wide mode

  wire [1:0] two_type = two_io ? 2'h0 : i_setup_two_type;
  wire two_prefetchable_flag = two_io ? 1'b0 : i_setup_two_prefetchable_flag;
  wire [31:0] view_two = {base_two[31:4], two_prefetchable_flag, two_type,
                          i_setup_two_space};
  wire three_prefetchable_flag = three_io ? 1'b0 : i_setup_three_prefetchable_flag;
  wire [31:0] view_three = two_wide ? base_three
                         : {base_three[31:4], three_prefetchable_flag,
                            `NBB_TYPE_NARROW, i_setup_three_space};
  wire [31:0] view_cfg = {base_cfg[31:7], 3'h0, 1'b0,
                          `NBB_TYPE_NARROW, `NBB_SPACE_MEM};

  reg [31:0] rdata_next;

  // unmapped offsets read zero but are still acknowledged
  always @* begin
    case (reg_sel)
      3'h1: begin
        rdata_next = view_two;
      end
      3'h2: begin
        rdata_next = view_three;
      end
      3'h4: begin
        rdata_next = view_cfg;
      end
      default: begin
        rdata_next = 32'h0;
      end
    endcase
  end

  ////////////////////////////////////////////////////////////////////////
  // address claim; a fixed one-cycle answer keeps the window count simple

  wire [63:0] cmp_mask_two = two_wide ? mask_two_full
                           : {32'hffffffff, mask_two};
  wire [63:0] cmp_base_two = {two_wide ? base_three : 32'h0, base_two};
  wire hit_two_next = i_req_valid && two_en && (i_req_is_io == two_io) &&
                      window_match(i_req_addr, cmp_base_two,
                                   cmp_mask_two);
  wire hit_three_next = i_req_valid && three_en && !two_wide &&
                        (i_req_is_io == three_io) &&
                        window_match(i_req_addr, {32'h0, base_three},
                                     {32'hffffffff, mask_three});
  wire hit_cfg_next = i_req_valid && !i_req_is_io &&
                      window_match(i_req_addr, {32'h0, base_cfg},
                                   {32'hffffffff, mask_cfg});

  ////////////////////////////////////////////////////////////////////////
  // register port answer, always one cycle after the strobe

  always @(posedge i_clock or negedge i_rst_b) begin
    if (!i_rst_b) begin
      o_reg_rdata <= 32'h0;
      o_reg_ack <= 1'b0;
    end else begin
      o_reg_rdata <= i_reg_rd ? rdata_next : 32'h0;
      o_reg_ack <= i_reg_rd | i_reg_wr;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // claim answer; the offset is zeroed off a hit so it never leaks

  always @(posedge i_clock or negedge i_rst_b) begin
    if (!i_rst_b) begin
      o_hit_two <= 1'b0;
      o_hit_three <= 1'b0;
      o_hit_cfg <= 1'b0;
      o_cfg_offset <= 12'h0;
    end else begin
      o_hit_two <= hit_two_next;
      o_hit_three <= hit_three_next;
      o_hit_cfg <= hit_cfg_next;
      o_cfg_offset <= hit_cfg_next ? i_req_addr[11:0] : 12'h0;
    end
  end
endmodule

// file: design/nbb_defines.vh
// constants for the bridge base address register block
`ifndef NBB_DEFINES_VH
`define NBB_DEFINES_VH

`define NBB_OFF_BAR_TWO 12'h018
`define NBB_OFF_BAR_THREE 12'h01c
`define NBB_OFF_CFG_WIN 12'h020

`define NBB_SPACE_BIT 0
`define NBB_TYPE_LSB 1
`define NBB_PREFETCHABLE_FLAG_BIT 3
`define NBB_BASE_ADDRESS_FIELD_LSB 4
`define NBB_CFG_BASE_ADDRESS_FIELD_LSB 7

`define NBB_SPACE_MEM 1'h0
`define NBB_SPACE_IO 1'h1
`define NBB_TYPE_NARROW 2'h0
`define NBB_TYPE_WIDE 2'h2

`define NBB_BASE_ADDRESS_FIELD_RESET 32'h0
`define NBB_CFG_WIN_LOG2 6'h0c
`define NBB_MIN_LOG2 6'h04
`define NBB_MAX_NARROW_LOG2 6'h1f

`endif

// file: design/nbb_bar_word.v
// one base address word whose writable bits follow a mask
`timescale 1ns/10ps
module nbb_bar_word #(
  parameter WIDTH = 32
) (
  input wire i_clock,
  input wire i_rst_b,
  input wire i_wr,
  input wire [WIDTH-1:0] i_wdata,
  input wire [WIDTH/8-1:0] i_be,
  input wire [WIDTH-1:0] i_mask,
  output wire [WIDTH-1:0] o_value
);
`include "nbb_defines.vh"

  reg [WIDTH-1:0] word_reg;
  reg [WIDTH-1:0] word_next;
  reg [WIDTH-1:0] lane_mask;
  integer k;

  always @* begin
    for (k = 0; k < WIDTH; k = k + 1) begin
      lane_mask[k] = i_be[k/8] & i_mask[k];
    end
    word_next = i_wr ? ((word_reg & ~lane_mask) | (i_wdata & lane_mask))
                     : word_reg;
  end

  always @(posedge i_clock or negedge i_rst_b) begin
    if (!i_rst_b) begin
      word_reg <= `NBB_BASE_ADDRESS_FIELD_RESET;
    end else begin
      word_reg <= word_next;
    end
  end

  // stale bits left below a grown window must never show
  assign o_value = word_reg & i_mask;
endmodule

// file: tb/nbb_base_regs_assertions.sv
// port assertions for the base address register block
`timescale 1ns/10ps
module nbb_base_regs_chk (
  input wire i_clock, i_rst_b, i_reg_wr, i_reg_rd,
  input wire [11:0] i_reg_addr,
  input wire i_setup_two_space, i_setup_two_prefetchable_flag, i_setup_three_space,
  input wire [1:0] i_setup_two_type,
  input wire i_req_valid, i_req_is_io,
  input wire [63:0] i_req_addr,
  input wire [31:0] o_reg_rdata,
  input wire o_reg_ack, o_hit_cfg,
  input wire [11:0] o_cfg_offset
);
  default clocking @(posedge i_clock); endclocking
  default disable iff (!i_rst_b);
  wire [11:0] req_low = i_req_addr[11:0];
  sequence s_rd(a); i_reg_rd && i_reg_addr == a; endsequence
  sequence s_cfg; i_req_valid ##1 o_hit_cfg; endsequence
  //////////
  property p_ack; (i_reg_rd || i_reg_wr) |=> o_reg_ack; endproperty
  a_ack: assert property (p_ack) else $error("no ack");
  property p_mir; s_rd(12'h018) ##0 !i_setup_two_space |=> o_reg_rdata[3:1]
    == {$past(i_setup_two_prefetchable_flag), $past(i_setup_two_type)}; endproperty
  a_mir: assert property (p_mir) else $error("mirror");
  property p_io; s_rd(12'h018) ##0 i_setup_two_space |=>
    o_reg_rdata[3:0] == 4'h1; endproperty
  a_io: assert property (p_io) else $error("io view");
  // io space in two rules out wide mode, so three keeps its own layout
  property p_three; s_rd(12'h01c) ##0 i_setup_two_space |=>
    o_reg_rdata[2:0] == {2'h0, $past(i_setup_three_space)}; endproperty
  a_three: assert property (p_three) else $error("three");
  property p_win; s_rd(12'h020) |=> o_reg_rdata[11:0] == 12'h0; endproperty
  a_win: assert property (p_win) else $error("window");
  property p_off; s_cfg |-> o_cfg_offset == $past(req_low); endproperty
  a_off: assert property (p_off) else $error("offset");
  property p_mem; i_req_valid && i_req_is_io |=> !o_hit_cfg; endproperty
  a_mem: assert property (p_mem) else $error("io hit");
  property p_idle; !i_req_valid |=> !o_hit_cfg && o_cfg_offset == 12'h0;
  endproperty
  a_idle: assert property (p_idle) else $error("stray hit");
endmodule
bind nbb_base_regs nbb_base_regs_chk chk_u (.*);

// file: tb/nbb_host_model.sv
// host model making configuration accesses
`timescale 1ns/10ps
module nbb_host_model (
  input wire i_clock, i_ack,
  input wire [31:0] i_rdata,
  output reg o_wr, o_rd,
  output reg [11:0] o_addr,
  output reg [31:0] o_wdata,
  output reg [3:0] o_be
);
  initial {o_wr, o_rd, o_addr, o_wdata, o_be} = 0;
  // waiting on each answer keeps reads outstanding below two
  task access(input w, input [11:0] a, input [31:0] d,
    output [31:0] q, output ok);
    @(negedge i_clock);
    {o_wr, o_rd, o_addr, o_wdata, o_be} = {w, !w, a, d, 4'hf};
    @(negedge i_clock);
    {o_wr, o_rd, o_addr, o_wdata} = {2'h0, ~a, ~d};
    ok = i_ack;
    q = i_rdata;
  endtask
endmodule

// file: tb/test_nbb_base_regs.sv
// bench for the base address register block
`timescale 1ns/10ps
module test_nbb_base_regs;
  reg i_clock = 0, i_rst_b = 0, i_req_valid = 0, i_req_is_io = 0;
  reg s2s = 0, s2p = 0, s3s = 0, s3p = 0, ok, wd;
  reg [1:0] s2t = 0;
  reg [5:0] s2z = 0, s3z = 0;
  reg [63:0] i_req_addr = 0, m2, m3;
  reg [31:0] lfsr = 32'hdcb1, q, d, b2 = 0, b3 = 0, bc = 0, w2, w3, v2, v3;
  wire i_reg_wr, i_reg_rd, o_reg_ack, o_hit_two, o_hit_three, o_hit_cfg;
  wire [3:0] i_reg_be;
  wire [11:0] i_reg_addr, o_cfg_offset;
  wire [31:0] i_reg_wdata, o_reg_rdata;
  integer errors = 0, n_tests = 0, i;
  always #2 i_clock = ~i_clock;
  nbb_host_model host_u (.i_clock(i_clock), .i_ack(o_reg_ack),
    .i_rdata(o_reg_rdata), .o_wr(i_reg_wr), .o_rd(i_reg_rd),
    .o_addr(i_reg_addr), .o_wdata(i_reg_wdata), .o_be(i_reg_be));
  nbb_base_regs dut_u (.*, .i_setup_two_space(s2s), .i_setup_two_type(s2t),
    .i_setup_two_prefetchable_flag(s2p), .i_setup_two_size(s2z),
    .i_setup_three_size(s3z), .i_setup_three_space(s3s),
    .i_setup_three_prefetchable_flag(s3p));
  //////////
  function [31:0] rnd(input x);
    lfsr = {lfsr[30:0], lfsr[31] ^ lfsr[21] ^ lfsr[1] ^ lfsr[0]};
    return lfsr;
  endfunction
  task chk(input [95:0] nm, input [63:0] e, input [63:0] g);
    n_tests = n_tests + 1;
    if (g !== e) begin
      errors = errors + 1;
      $display("unexpected %0s: expected %h seen %h", nm, e, g);
    end
  endtask
  task end_sim;
    $display("checks %0d mismatches %0d", n_tests, errors);
    if (errors == 0 && n_tests > 0) $display("Testbench passed");
    else $display("Testbench failed");
    $finish;
  endtask
  task acc(input w, input [11:0] a, input [31:0] dd, input [31:0] e);
    host_u.access(w, a, dd, q, ok);
    chk("ack", 1, ok);
    if (!w) chk("rdata", e, q);
  endtask
  task claim(input [63:0] a, input io);
    @(negedge i_clock);
    {i_req_valid, i_req_addr, i_req_is_io} = {1'b1, a, io};
    @(negedge i_clock);
    {i_req_valid, i_req_addr} = {1'b0, ~a};
  endtask
  //////////
  initial begin
    repeat (2) @(negedge i_clock);
    i_rst_b = 1;
    for (i = 0; i < 16; i = i + 1) begin
      q = rnd(0);
      {s2s, s2p, s3s, s3p, s2t, s3z} = {q[3:0], q[5:4], 1'b0, q[20:16]};
      s2z = 6'h04 + q[9:6] + q[13:10];
      wd = !s2s && s2t == 2'h2;
      m2 = ~((64'h1 << s2z) - 64'h1);
      m3 = s3z < 4 ? 64'h0 : ~((64'h1 << s3z) - 64'h1);
      w2 = m2[31:0] & 32'hfffffff0;
      w3 = wd ? m2[63:32] : m3[31:0] & 32'hfffffff0;
      v2 = b2 & w2 | {28'h0, !s2s & s2p, s2s ? 2'h0 : s2t, s2s};
      v3 = b3 & w3 | {28'h0, !wd & !s3s & s3p, 2'h0, !wd & s3s};
      acc(0, 12'h018, 0, v2);
      acc(0, 12'h01c, 0, v3);
      acc(0, 12'h020, 0, bc);
      acc(0, 12'h024, 0, 0);
      claim({wd ? v3 : 32'h0, v2 & 32'hfffffff0}, s2s);
      chk("hit two", wd | s2z < 32, o_hit_two);
      claim({32'h0, v3 & 32'hfffffff0}, s3s);
      chk("hit three", !wd & s3z > 3, o_hit_three);
      claim({32'h0, bc | lfsr[11:0]}, 0);
      chk("hit cfg", 1, o_hit_cfg);
      chk("offset", lfsr[11:0], o_cfg_offset);
      d = rnd(0);
      acc(1, 12'h018, d, 0);
      acc(1, 12'h01c, ~d, 0);
      acc(1, 12'h020, d, 0);
      acc(1, 12'h024, ~d, 0);
      b2 = b2 & ~w2 | d & w2;
      b3 = b3 & ~w3 | ~d & w3;
      bc = d & 32'hfffff000;
      $display("round %0d done", i);
    end
    end_sim;
  end
endmodule
